// ### rtl/tlb_address_space_tagging.sv
`timescale 1ns/1ns
// Functional notes
// - three saved origins tied to codes 1-3
// - exactly one code is active once an origin is loaded
// - new entries carry the active code
// - code mismatch on lookup means miss
// - origin load compared against all saved origins
// - matching origin reselects code, no purge
// - new origin takes fifo slot, becomes active
// - displaced code purges only its entries
// - entry code zero means invalid
// - translate program, branch, operand, lra, event addresses
// - key, channel list, non-storage addresses untranslated
// - table origins and frames used as real
// - timer and failing address locations are real
// - store fault address at 144, event at 152
// - console virtual request walks tables, skips buffer
// - console alter purges whole buffer
// - console shows virtual and real or error
// - set counter follows mode bit, compare real
// - 64 sets of two, odd/even way
// - reset invalidates all entries and saved segment
module tlb_address_space_tagging (
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire logic dat_on_i,
    input wire logic psw_translate_i,
    input wire logic cr0_seg_1m_i,
    input wire logic cr1_load_i,
    input wire logic [tlb_tag_pkg::STO_W-1:0] cr1_sto_i,
    input wire logic [tlb_tag_pkg::STL_W-1:0] cr1_stl_i,
    input wire tlb_tag_pkg::cpu_req_t cpu_req_i,
    output tlb_tag_pkg::cpu_rsp_t cpu_rsp_o,
    input wire tlb_tag_pkg::con_req_t con_req_i,
    output tlb_tag_pkg::con_rsp_t con_rsp_o,
    input wire logic per_event_i,
    input wire logic [tlb_tag_pkg::VA_W-1:0] per_addr_i,
    output logic mem_rd_o,
    output logic [tlb_tag_pkg::VA_W-1:0] mem_addr_o,
    input wire logic [tlb_tag_pkg::MEM_W-1:0] mem_rdata_i,
    input wire logic mem_ack_i,
    output tlb_tag_pkg::store_t store_o,
    output logic [1:0] active_code_o,
    output logic busy_o
);
    typedef enum logic [2:0] {st_idle, st_walk, st_ste, st_chk, st_pte} walk_fsm_t;

    typedef struct packed {
        walk_fsm_t fsm;
        logic busy;
        logic from_con;
        tlb_tag_pkg::cpu_req_t creq;
        tlb_tag_pkg::con_req_t kreq;
        logic [tlb_tag_pkg::STO_W-1:0] cr1_sto;
        logic [tlb_tag_pkg::STL_W-1:0] cr1_stl;
        logic ste_ok;
        logic [tlb_tag_pkg::SEG_IDX_W-1:0] ste_seg;
        logic [tlb_tag_pkg::MEM_W-1:0] ste;
        logic mem_rd;
        logic [tlb_tag_pkg::VA_W-1:0] mem_addr;
        tlb_tag_pkg::cpu_rsp_t cpu_rsp;
        tlb_tag_pkg::con_rsp_t con_rsp;
        tlb_tag_pkg::store_t store;
        logic per_pend;
        logic [tlb_tag_pkg::VA_W-1:0] per_addr;
    } top_state_t;

    top_state_t st, next_st;

    logic [tlb_tag_pkg::VA_W-1:0] walk_va;
    logic [tlb_tag_pkg::SEG_IDX_W-1:0] seg_idx;
    logic [tlb_tag_pkg::SEG_IDX_W-1:0] pg_idx;
    logic [tlb_tag_pkg::STL_W-1:0] ste_ptl;
    logic [tlb_tag_pkg::STE_PTO_W-1:0] ste_pto;
    logic fin;
    logic fin_exc;
    logic [tlb_tag_pkg::FRAME_W-1:0] fin_frame;
    logic con_virt;
    logic purge_now;
    logic fill_now;
    logic look_hit;
    logic [tlb_tag_pkg::FRAME_W-1:0] look_frame;
    logic [1:0] active_code;
    logic purge;
    logic [1:0] purge_code;
    logic [tlb_tag_pkg::VA_W-1:0] pass_addr;

    origin_save u_origin_save (
        .sys_clk_i(sys_clk_i),
        .resetn_i(resetn_i),
        .load_i(cr1_load_i),
        .sto_i(cr1_sto_i),
        .active_code_o(active_code),
        .purge_o(purge),
        .purge_code_o(purge_code)
    );

    // lookup runs on the live request address so a hit costs no walk cycle
    tlb_array u_tlb_array (
        .sys_clk_i(sys_clk_i),
        .resetn_i(resetn_i),
        .look_vaddr_i(cpu_req_i.vaddr),
        .active_code_i(active_code),
        .hit_o(look_hit),
        .frame_o(look_frame),
        .fill_i(fill_now),
        .fill_vaddr_i(st.creq.vaddr),
        .fill_frame_i(fin_frame),
        .purge_i(purge),
        .purge_code_i(purge_code),
        .purge_all_i(purge_now)
    );

    // untranslated classes; timer and failing-address stores hit fixed real words
    always_comb begin
        unique case (cpu_req_i.cls)
            tlb_tag_pkg::cls_timer: pass_addr = {16'h0000, tlb_tag_pkg::LOC_TIMER};
            tlb_tag_pkg::cls_fail_addr: pass_addr = {16'h0000, tlb_tag_pkg::LOC_FAIL_ADDR};
            default: pass_addr = cpu_req_i.vaddr;
        endcase
    end

    always_comb begin
        next_st = st;
        walk_va = st.from_con ? st.kreq.addr : st.creq.vaddr;
        if (cr0_seg_1m_i) begin
            seg_idx = {4'h0, walk_va[tlb_tag_pkg::VA_W-1:tlb_tag_pkg::SEG_LSB_1M]};
            pg_idx = walk_va[tlb_tag_pkg::SEG_LSB_1M-1:tlb_tag_pkg::IDX_LSB];
        end else begin
            seg_idx = walk_va[tlb_tag_pkg::VA_W-1:tlb_tag_pkg::SEG_LSB_64K];
            pg_idx = {4'h0, walk_va[tlb_tag_pkg::SEG_LSB_64K-1:tlb_tag_pkg::IDX_LSB]};
        end
        ste_ptl = st.ste[tlb_tag_pkg::STE_PTL_LSB +: tlb_tag_pkg::STL_W];
        ste_pto = st.ste[tlb_tag_pkg::STE_PTO_LSB +: tlb_tag_pkg::STE_PTO_W];
        fin = 1'b0;
        fin_exc = 1'b0;
        fin_frame = mem_rdata_i[tlb_tag_pkg::PTE_FRAME_LSB +: tlb_tag_pkg::FRAME_W];
        con_virt = con_req_i.virt;
        purge_now = 1'b0;
        next_st.cpu_rsp.valid = 1'b0;
        next_st.con_rsp.valid = 1'b0;
        next_st.store.valid = 1'b0;
        if (cr1_load_i) begin
            // a new table origin makes the saved segment entry meaningless
            next_st.cr1_sto = cr1_sto_i;
            next_st.cr1_stl = cr1_stl_i;
            next_st.ste_ok = 1'b0;
        end
        unique case (st.fsm)
            st_idle: begin
                if (cpu_req_i.valid) begin
                    next_st.creq = cpu_req_i;
                    next_st.from_con = 1'b0;
                    if (!(dat_on_i &&
                        tlb_tag_pkg::needs_translation(cpu_req_i.cls))) begin
                        next_st.cpu_rsp.valid = 1'b1;
                        next_st.cpu_rsp.hit = 1'b0;
                        next_st.cpu_rsp.exc = 1'b0;
                        next_st.cpu_rsp.translated = 1'b0;
                        next_st.cpu_rsp.raddr = pass_addr;
                    end else if (look_hit) begin
                        next_st.cpu_rsp.valid = 1'b1;
                        next_st.cpu_rsp.hit = 1'b1;
                        next_st.cpu_rsp.exc = 1'b0;
                        next_st.cpu_rsp.translated = 1'b1;
                        next_st.cpu_rsp.raddr =
                            {look_frame, cpu_req_i.vaddr[tlb_tag_pkg::OFF_W-1:0]};
                    end else begin
                        next_st.fsm = st_walk;
                    end
                end else if (con_req_i.valid) begin
                    next_st.kreq = con_req_i;
                    next_st.from_con = 1'b1;
                    if (con_req_i.op == tlb_tag_pkg::con_set_instruction_counter) begin
                        con_virt = psw_translate_i;
                    end else if (con_req_i.op == tlb_tag_pkg::con_addr_compare) begin
                        con_virt = 1'b0;
                    end
                    if (con_virt) begin
                        next_st.fsm = st_walk;
                    end else begin
                        next_st.con_rsp.valid = 1'b1;
                        next_st.con_rsp.err = 1'b0;
                        next_st.con_rsp.vaddr = con_req_i.addr;
                        next_st.con_rsp.raddr = con_req_i.addr;
                        purge_now = con_req_i.op == tlb_tag_pkg::con_alter;
                    end
                end
            end
            st_walk: begin
                if (seg_idx[tlb_tag_pkg::SEG_IDX_W-1:tlb_tag_pkg::STL_W] > st.cr1_stl) begin
                    fin = 1'b1;
                    fin_exc = 1'b1;
                end else if (st.ste_ok && st.ste_seg == seg_idx) begin
                    // same segment as last walk: skip the segment-table read
                    next_st.fsm = st_chk;
                end else begin
                    next_st.mem_rd = 1'b1;
                    next_st.mem_addr = {st.cr1_sto, 6'h00} + {14'h0000, seg_idx, 2'h0};
                    next_st.fsm = st_ste;
                end
            end
            st_ste: begin
                if (mem_ack_i) begin
                    next_st.mem_rd = 1'b0;
                    next_st.ste = mem_rdata_i;
                    next_st.ste_ok = 1'b1;
                    next_st.ste_seg = seg_idx;
                    next_st.fsm = st_chk;
                end
            end
            st_chk: begin
                if (st.ste[tlb_tag_pkg::STE_INV] ||
                    pg_idx[tlb_tag_pkg::SEG_IDX_W-1:tlb_tag_pkg::STL_W] > ste_ptl) begin
                    fin = 1'b1;
                    fin_exc = 1'b1;
                end else begin
                    next_st.mem_rd = 1'b1;
                    next_st.mem_addr = {ste_pto, 3'h0} + {15'h0000, pg_idx, 1'h0};
                    next_st.fsm = st_pte;
                end
            end
            st_pte: begin
                if (mem_ack_i) begin
                    next_st.mem_rd = 1'b0;
                    fin = 1'b1;
                    fin_exc = mem_rdata_i[tlb_tag_pkg::PTE_INV];
                end
            end
            default: begin
                next_st.fsm = st_idle;
            end
        endcase

        fill_now = fin && !st.from_con && !fin_exc;
        if (fin) begin
            next_st.fsm = st_idle;
            if (st.from_con) begin
                next_st.con_rsp.valid = 1'b1;
                next_st.con_rsp.err = fin_exc;
                next_st.con_rsp.vaddr = walk_va;
                next_st.con_rsp.raddr = fin_exc ? '0 :
                    {fin_frame, walk_va[tlb_tag_pkg::OFF_W-1:0]};
                purge_now = st.kreq.op == tlb_tag_pkg::con_alter;
            end else begin
                next_st.cpu_rsp.valid = 1'b1;
                next_st.cpu_rsp.hit = 1'b0;
                next_st.cpu_rsp.exc = fin_exc;
                next_st.cpu_rsp.translated = 1'b1;
                next_st.cpu_rsp.raddr = fin_exc ? '0 :
                    {fin_frame, walk_va[tlb_tag_pkg::OFF_W-1:0]};
                // explicit real-address loads report by condition code, not by interruption
                if (fin_exc && st.creq.cls != tlb_tag_pkg::cls_lra) begin
                    next_st.store.valid = 1'b1;
                    next_st.store.loc = tlb_tag_pkg::LOC_XLATE_EXC;
                    next_st.store.data = walk_va;
                end
            end
        end

        // event store waits one cycle if a fault store holds the port
        if (st.per_pend && !next_st.store.valid) begin
            next_st.store.valid = 1'b1;
            next_st.store.loc = tlb_tag_pkg::LOC_PER;
            next_st.store.data = st.per_addr;
            next_st.per_pend = 1'b0;
        end
        if (per_event_i) begin
            next_st.per_pend = 1'b1;
            next_st.per_addr = per_addr_i;
        end
        if (purge_now) begin
            next_st.ste_ok = 1'b0;
        end
        next_st.busy = next_st.fsm != st_idle;
    end

    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            st <= '0;
            st.fsm <= st_idle;
        end else begin
            st <= next_st;
        end
    end

    assign cpu_rsp_o = st.cpu_rsp;
    assign con_rsp_o = st.con_rsp;
    assign store_o = st.store;
    assign mem_rd_o = st.mem_rd;
    assign mem_addr_o = st.mem_addr;
    assign busy_o = st.busy;
    assign active_code_o = active_code;

    sequence s_miss_start;
        st.fsm == st_idle && cpu_req_i.valid && dat_on_i &&
            tlb_tag_pkg::needs_translation(cpu_req_i.cls) && !look_hit;
    endsequence

    sequence s_walk_begun;
        busy_o && !cpu_rsp_o.valid;
    endsequence

    a_untranslated_pass: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        st.fsm == st_idle && cpu_req_i.valid && !dat_on_i |=>
            cpu_rsp_o.valid && !cpu_rsp_o.translated && !busy_o)
        else $error("untranslated request not answered next cycle");
    a_hit_one_cycle: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        st.fsm == st_idle && cpu_req_i.valid && dat_on_i &&
            tlb_tag_pkg::needs_translation(cpu_req_i.cls) && look_hit |=>
            cpu_rsp_o.valid && cpu_rsp_o.hit && cpu_rsp_o.raddr[tlb_tag_pkg::OFF_W-1:0] ==
            $past(cpu_req_i.vaddr[tlb_tag_pkg::OFF_W-1:0]))
        else $error("buffer hit not answered with hit");
    a_miss_walks: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        s_miss_start |=> s_walk_begun)
        else $error("buffer miss did not start a table walk");
    a_fault_store: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        cpu_rsp_o.valid && cpu_rsp_o.exc && st.creq.cls != tlb_tag_pkg::cls_lra |->
            store_o.valid && store_o.loc == tlb_tag_pkg::LOC_XLATE_EXC &&
            store_o.data == st.creq.vaddr)
        else $error("faulting address not stored at 144");
    a_event_store: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        per_event_i |-> ##[2:3] store_o.valid && store_o.loc == tlb_tag_pkg::LOC_PER)
        else $error("event address not stored at 152");
    a_alter_purges: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        con_rsp_o.valid && st.kreq.op == tlb_tag_pkg::con_alter |-> $past(purge_now))
        else $error("console alter did not purge buffer");
    a_con_error: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        con_rsp_o.valid && con_rsp_o.err |-> con_rsp_o.raddr == '0 &&
            con_rsp_o.vaddr == st.kreq.addr)
        else $error("console error answer malformed");
    a_reset_quiet: assert property (@(posedge sys_clk_i)
        !resetn_i |=> !busy_o && !mem_rd_o && !cpu_rsp_o.valid && !store_o.valid)
        else $error("outputs not idle after reset");
    a_timer_real: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        st.fsm == st_idle && cpu_req_i.valid && cpu_req_i.cls == tlb_tag_pkg::cls_timer |=>
            cpu_rsp_o.raddr == {16'h0000, tlb_tag_pkg::LOC_TIMER})
        else $error("timer address was translated");
    a_compare_real: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        st.fsm == st_idle && !cpu_req_i.valid && con_req_i.valid &&
            con_req_i.op == tlb_tag_pkg::con_addr_compare |=> con_rsp_o.valid && !busy_o)
        else $error("address compare request was translated");
endmodule

// ### rtl/tlb_tag_pkg.sv
package tlb_tag_pkg;
    localparam int VA_W = 24;
    localparam int STO_W = 18;
    localparam int FRAME_W = 12;
    localparam int OFF_W = 12;
    localparam int TAG_W = 5;
    localparam int TAG_LSB = 19;
    localparam int IDX_W = 7;
    localparam int IDX_LSB = 12;
    localparam int NUM_SETS = 64;
    localparam int NUM_ENTRIES = 128;
    localparam int NUM_SLOTS = 3;
    localparam logic [1:0] CODE_NONE = 2'h0;
    localparam logic [1:0] CODE_FIRST = 2'h1;
    localparam logic [1:0] CODE_LAST = 2'h3;
    localparam int STO_ALIGN = 6;
    localparam int PTO_ALIGN = 3;
    localparam int SEG_LSB_64K = 16;
    localparam int SEG_LSB_1M = 20;
    localparam int SEG_IDX_W = 8;
    localparam int STL_W = 4;
    localparam int STE_INV = 0;
    localparam int STE_PTO_LSB = 3;
    localparam int STE_PTO_W = 21;
    localparam int STE_PTL_LSB = 28;
    localparam int PTE_INV = 3;
    localparam int PTE_FRAME_LSB = 4;
    localparam int MEM_W = 32;
    localparam logic [7:0] LOC_TIMER = 8'h50;
    localparam logic [7:0] LOC_XLATE_EXC = 8'h90;
    localparam logic [7:0] LOC_PER = 8'h98;
    localparam logic [7:0] LOC_FAIL_ADDR = 8'hf8;

    typedef enum logic [3:0] {
        cls_instr, cls_branch, cls_operand, cls_lra, cls_per_start, cls_per_end,
        cls_key_op, cls_ccw, cls_no_storage, cls_table_origin, cls_timer, cls_fail_addr
    } addr_class_t;

    typedef enum logic [1:0] {con_display, con_alter, con_set_instruction_counter, con_addr_compare} con_op_t;

    typedef struct packed {
        logic [1:0] code;
        logic [TAG_W-1:0] vtag;
        logic [FRAME_W-1:0] frame;
    } tlb_entry_t;

    typedef struct packed {
        logic valid;
        logic [VA_W-1:0] vaddr;
        addr_class_t cls;
    } cpu_req_t;

    typedef struct packed {
        logic valid;
        con_op_t op;
        logic virt;
        logic [VA_W-1:0] addr;
    } con_req_t;

    typedef struct packed {
        logic valid;
        logic hit;
        logic exc;
        logic translated;
        logic [VA_W-1:0] raddr;
    } cpu_rsp_t;

    typedef struct packed {
        logic valid;
        logic err;
        logic [VA_W-1:0] vaddr;
        logic [VA_W-1:0] raddr;
    } con_rsp_t;

    typedef struct packed {
        logic valid;
        logic [7:0] loc;
        logic [VA_W-1:0] data;
    } store_t;

    function automatic logic needs_translation(addr_class_t c);
        return c inside {cls_instr, cls_branch, cls_operand, cls_lra, cls_per_start, cls_per_end};
    endfunction
endpackage

// ### rtl/origin_save.sv
`timescale 1ns/1ns
module origin_save (
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire logic load_i,
    input wire logic [tlb_tag_pkg::STO_W-1:0] sto_i,
    output logic [1:0] active_code_o,
    output logic purge_o,
    output logic [1:0] purge_code_o
);
    typedef struct packed {
        logic [tlb_tag_pkg::NUM_SLOTS-1:0] used;
        logic [tlb_tag_pkg::NUM_SLOTS-1:0][tlb_tag_pkg::STO_W-1:0] sto;
        logic [1:0] active;
        logic [1:0] fifo_code;
    } save_state_t;

    save_state_t st, next_st;
    logic match;
    logic [1:0] match_code;
    logic [1:0] slot;

    always_comb begin
        next_st = st;
        match = 1'b0;
        match_code = tlb_tag_pkg::CODE_NONE;
        slot = st.fifo_code - tlb_tag_pkg::CODE_FIRST;
        purge_o = 1'b0;
        purge_code_o = st.fifo_code;
        for (int i = 0; i < tlb_tag_pkg::NUM_SLOTS; i++) begin
            if (st.used[i] && st.sto[i] == sto_i) begin
                match = 1'b1;
                match_code = 2'(i + 1);
            end
        end
        if (load_i) begin
            if (match) begin
                next_st.active = match_code;
            end else begin
                // purge is issued with the load so no stale hit can slip in
                purge_o = st.used[slot];
                next_st.used[slot] = 1'b1;
                next_st.sto[slot] = sto_i;
                next_st.active = st.fifo_code;
                next_st.fifo_code = (st.fifo_code == tlb_tag_pkg::CODE_LAST) ?
                    tlb_tag_pkg::CODE_FIRST : st.fifo_code + tlb_tag_pkg::CODE_FIRST;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            st <= '0;
            st.fifo_code <= tlb_tag_pkg::CODE_FIRST;
        end else begin
            st <= next_st;
        end
    end

    assign active_code_o = st.active;

    a_load_sets_active: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        load_i |=> active_code_o != tlb_tag_pkg::CODE_NONE)
        else $error("active code not set after origin load");
    a_match_no_purge: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        load_i && match |-> !purge_o ##1 active_code_o == $past(match_code))
        else $error("matching origin caused purge or wrong code");
    a_fifo_assign: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        load_i && !match |=> active_code_o == $past(st.fifo_code))
        else $error("new origin did not take the fifo code");
endmodule

// ### rtl/tlb_array.sv
`timescale 1ns/1ns
module tlb_array (
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire logic [tlb_tag_pkg::VA_W-1:0] look_vaddr_i,
    input wire logic [1:0] active_code_i,
    output logic hit_o,
    output logic [tlb_tag_pkg::FRAME_W-1:0] frame_o,
    input wire logic fill_i,
    input wire logic [tlb_tag_pkg::VA_W-1:0] fill_vaddr_i,
    input wire logic [tlb_tag_pkg::FRAME_W-1:0] fill_frame_i,
    input wire logic purge_i,
    input wire logic [1:0] purge_code_i,
    input wire logic purge_all_i
);
    typedef struct packed {
        tlb_tag_pkg::tlb_entry_t [tlb_tag_pkg::NUM_ENTRIES-1:0] ent;
    } array_state_t;

    array_state_t st, next_st;
    tlb_tag_pkg::tlb_entry_t look;
    logic [tlb_tag_pkg::IDX_W-1:0] fill_idx;
    logic [3:0] code_present;

    // set index plus odd/even page bit form one seven-bit entry index
    assign look = st.ent[look_vaddr_i[tlb_tag_pkg::IDX_LSB +: tlb_tag_pkg::IDX_W]];
    assign fill_idx = fill_vaddr_i[tlb_tag_pkg::IDX_LSB +: tlb_tag_pkg::IDX_W];

    always_comb begin
        next_st = st;
        code_present = 4'h0;
        for (int i = 0; i < tlb_tag_pkg::NUM_ENTRIES; i++) begin
            code_present[st.ent[i].code] = 1'b1;
            if (purge_all_i || (purge_i && st.ent[i].code == purge_code_i)) begin
                next_st.ent[i].code = tlb_tag_pkg::CODE_NONE;
            end
        end
        if (fill_i) begin
            next_st.ent[fill_idx].code = active_code_i;
            next_st.ent[fill_idx].vtag = fill_vaddr_i[tlb_tag_pkg::TAG_LSB +: tlb_tag_pkg::TAG_W];
            next_st.ent[fill_idx].frame = fill_frame_i;
        end
        hit_o = look.code != tlb_tag_pkg::CODE_NONE && look.code == active_code_i &&
            look.vtag == look_vaddr_i[tlb_tag_pkg::TAG_LSB +: tlb_tag_pkg::TAG_W];
        frame_o = look.frame;
    end

    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    a_purge_code_gone: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        purge_i && !fill_i |=> !code_present[$past(purge_code_i)])
        else $error("entries with displaced code survived purge");
    a_reset_empty: assert property (@(posedge sys_clk_i)
        !resetn_i |=> code_present[3:1] == 3'h0)
        else $error("buffer not empty after reset");
endmodule

// ### verification/table_mem_model.sv
`timescale 1ns/1ns
module table_mem_model #(parameter int LAT = 0) (
    input wire logic sys_clk_i,
    input wire logic mem_rd_i,
    input wire logic [23:0] mem_addr_i,
    output logic mem_ack_o,
    output logic [31:0] mem_rdata_o
);
    int cnt = 0;
    initial begin
        mem_ack_o = 1'h0;
        mem_rdata_o = 32'h0;
    end
    // bit 23 picks page table area; page 15 entries are marked invalid
    always @(posedge sys_clk_i) begin
        #1;
        if (mem_rd_i && !mem_ack_o && cnt >= LAT) begin
            mem_ack_o = 1'h1;
            cnt = 0;
            if (mem_addr_i[23]) begin
                mem_rdata_o = {16'h0, mem_addr_i[12:1], mem_addr_i[4:1] == 4'hf, 3'h0};
            end else begin
                mem_rdata_o = {8'hf0, 1'h1, mem_addr_i[19:0], 3'h0};
            end
        end else begin
            // stale data must not look valid once released
            mem_ack_o = 1'h0;
            mem_rdata_o = ~mem_rdata_o;
            cnt = mem_rd_i ? cnt + 1 : 0;
        end
    end
endmodule

// ### verification/tlb_address_space_tagging_tb.sv
`timescale 1ns/1ns
module tlb_address_space_tagging_tb;
    logic sys_clk_i = 0, resetn_i = 0, dat_on_i = 1, psw_translate_i = 0, cr1_load_i = 0;
    logic per_event_i = 0, mem_rd_o, mem_ack_i, busy_o;
    logic [17:0] cr1_sto_i = '0;
    logic [23:0] mem_addr_o;
    logic [31:0] mem_rdata_i;
    logic [1:0] active_code_o;
    tlb_tag_pkg::cpu_req_t cpu_req_i = '0;
    tlb_tag_pkg::con_req_t con_req_i = '0;
    tlb_tag_pkg::cpu_rsp_t cpu_rsp_o, r;
    tlb_tag_pkg::con_rsp_t con_rsp_o;
    tlb_tag_pkg::store_t store_o, st;
    int fail_count = 0, checked = 0;
    localparam logic [23:0] V = 24'h123456;
    localparam logic [23:0] F = 24'h12f456;
    always #4 sys_clk_i = ~sys_clk_i;
    tlb_address_space_tagging DUT (.sys_clk_i, .resetn_i, .dat_on_i, .psw_translate_i,
        .cr0_seg_1m_i(1'h0), .cr1_load_i, .cr1_sto_i, .cr1_stl_i(4'hf), .cpu_req_i,
        .cpu_rsp_o, .con_req_i, .con_rsp_o, .per_event_i, .per_addr_i(V), .mem_rd_o,
        .mem_addr_o, .mem_rdata_i, .mem_ack_i, .store_o, .active_code_o, .busy_o);
    table_mem_model #(.LAT(1)) mem (.sys_clk_i, .mem_rd_i(mem_rd_o), .mem_addr_i(mem_addr_o),
        .mem_ack_o(mem_ack_i), .mem_rdata_o(mem_rdata_i));
    task automatic chk(input logic [63:0] g, e);
        checked++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic tick();
        @(posedge sys_clk_i);
        #1;
    endtask
    task automatic req(input int c, input logic [23:0] a);
        tick();
        cpu_req_i = '{1'h1, a, tlb_tag_pkg::addr_class_t'(c)};
        tick();
        cpu_req_i.valid = 1'h0;
        for (int i = 0; i < 20 && cpu_rsp_o.valid !== 1'h1; i++) tick();
        r = cpu_rsp_o;
        st = store_o;
        chk(r.valid, 1'h1);
    endtask
    task automatic con(input int op, input logic v, input logic [23:0] a, input logic [63:0] e);
        tick();
        con_req_i = '{1'h1, tlb_tag_pkg::con_op_t'(op), v, a};
        tick();
        con_req_i.valid = 1'h0;
        for (int i = 0; i < 20 && con_rsp_o.valid !== 1'h1; i++) tick();
        chk({con_rsp_o.valid, con_rsp_o.err, con_rsp_o.vaddr, con_rsp_o.raddr}, e);
    endtask
    task automatic load(input int k);
        tick();
        cr1_sto_i = 18'(k * 1024);
        cr1_load_i = 1'h1;
        tick();
        cr1_load_i = 1'h0;
    endtask
    // origin k places its segment table at k * 64K
    function automatic logic [23:0] ex(input int k, input logic [23:0] a);
        logic [23:0] p;
        p = 24'(k * 65536) + {14'h0, a[23:16], 2'h0};
        p = {1'h1, p[19:0], 3'h0} + {19'h0, a[15:12], 1'h0};
        return {p[12:1], a[11:0]};
    endfunction
    task automatic t_spaces();
        int ks[8] = '{1, 1, 2, 1, 3, 4, 4, 2};
        int ps[8] = '{1, 1, 2, 1, 3, 4, 1, 2};
        int cs[8] = '{1, 1, 2, 1, 3, 1, 1, 2};
        int hs[8] = '{0, 1, 0, 1, 0, 0, 0, 1};
        logic [23:0] a;
        // one buffer index per space except space 4, which also reuses page 1's, so a return to a kept space can still hit
        foreach (ks[i]) begin
            a = V + 24'(ps[i] * 8192);
            load(ks[i]);
            req(2, a);
            chk({active_code_o, r.hit, r.raddr},
                {cs[i][1:0], hs[i][0], ex(ks[i], a)});
        end
        $display("test spaces done");
    endtask
    task automatic t_classes();
        for (int c = 6; c < 12; c++) begin
            req(c, V);
            chk({r.translated, r.raddr},
                {1'h0, c == 10 ? 24'h50 : c == 11 ? 24'hf8 : V});
        end
        dat_on_i = 1'h0;
        req(0, V);
        chk({r.translated, r.raddr}, {1'h0, V});
        dat_on_i = 1'h1;
        req(5, V);
        chk({r.translated, r.raddr}, {1'h1, ex(2, V)});
        $display("test classes done");
    endtask
    task automatic t_fault();
        req(2, F);
        chk({r.exc, r.raddr, st.valid, st.loc, st.data},
            {25'h1000000, 1'h1, 8'h90, F});
        per_event_i = 1'h1;
        tick();
        per_event_i = 1'h0;
        if (store_o.valid !== 1'h1) tick();
        chk({store_o.valid, store_o.loc, store_o.data}, {1'h1, 8'h98, V});
        $display("test fault done");
    endtask
    task automatic t_console();
        con(0, 1'h1, V, {2'h2, V, ex(2, V)});
        con(0, 1'h1, F, {2'h3, F, 24'h0});
        con(2, 1'h0, V, {2'h2, V, V});
        psw_translate_i = 1'h1;
        con(2, 1'h0, V, {2'h2, V, ex(2, V)});
        con(3, 1'h1, V, {2'h2, V, V});
        con(1, 1'h1, V, {2'h2, V, ex(2, V)});
        req(2, V);
        chk({r.hit, r.raddr}, {1'h0, ex(2, V)});
        $display("test console done");
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge sys_clk_i);
        #1;
        resetn_i = 1'h1;
        chk({active_code_o, busy_o, mem_rd_o, cpu_rsp_o.valid}, 5'h0);
        $display("test reset done");
        t_spaces();
        t_classes();
        t_fault();
        t_console();
        complete_run();
    end
    initial begin
        repeat (3000) @(posedge sys_clk_i);
        fail_count++;
        complete_run();
    end
endmodule
